// file: core/backplane_stats_defs.vh
// Constants for the backplane port statistics bank
`ifndef BACKPLANE_STATS_DEFS_VH
`define BACKPLANE_STATS_DEFS_VH

// Clock and timing
`define CLK_HZ 25000000
`define FAULT_HOLD_MS 1000
`define FAULT_HOLD_CYCLES (`FAULT_HOLD_MS * (`CLK_HZ / 1000))
`define IDLE_TIMEOUT_MS 30000
`define IDLE_TIMEOUT_CYCLES (`IDLE_TIMEOUT_MS * (`CLK_HZ / 1000))

// Widths and limits
`define STAT_WIDTH 16
`define MAX_ACTIVE_BLOCKS 3'h4
`define PENDING_MAX 4'hF
`define NUM_COUNTERS 22

// Exception code for a missing host path
`define EXC_GATEWAY_PATH 8'h0A

// Register indices; byte address is four times the index
`define REG_REPLIES_RECEIVED 12'h861
`define REG_ERROR_RESPONSES_MADE 12'h862
`define REG_ORPHAN_REPLIES_DROPPED 12'h863
`define REG_MESSAGES_ORIGINATED 12'h864
`define REG_BUFFER_STARVATION 12'h865
`define REG_MEMORY_REQUESTS_QUEUED 12'h866
`define REG_CONTEXT_EXHAUSTED 12'h867
`define REG_ACTIVE_BLOCK_GAUGE 12'h868
`define REG_UNTRANSLATABLE_DROPPED 12'h869
`define REG_MALFORMED_MESSAGES 12'h86A
`define REG_LOGGED_ON_CHANNEL_MSGS 12'h86B
`define REG_GUEST_CHANNEL_MSGS 12'h86C
`define REG_MEMORY_REQUESTS_SERVED 12'h86D
`define REG_BLOCK_OPS_STARTED 12'h86E
`define REG_IDLE_EXPIRIES 12'h86F
`define REG_BAD_OPCODE_COUNT 12'h870
`define REG_BLOCK_OPS_DONE 12'h871
`define REG_CHANNEL_MSGS_SERVED 12'h872
`define REG_NO_RACK_ERRORS 12'h873
`define REG_SCAN_END_HOOKS 12'h875
`define REG_LOGIC_HOOKS 12'h876
`define REG_QUEUED_BUFFER_GAUGE 12'h877
`define REG_LOGON_CLAIMED 12'h878
`define REG_POWERUP_HOOKS 12'h879
`define REG_EXIT_DIM_HOOKS 12'h87A
`define REG_BUFFERS_HELD_GAUGE 12'h880
`define REG_STATS_CONTROL 12'h881
`define REG_PORT_STATUS 12'h882

// Control register fields
`define CTRL_ZERO_BIT 0
`define CTRL_LAMP_EN_BIT 1
`define CTRL_LAMP_EN_RESET 1'h1

// Counter slots
`define SLOT_REPLIES 0
`define SLOT_ERR_RESP 1
`define SLOT_ORPHAN 2
`define SLOT_ORIGINATED 3
`define SLOT_STARVED 4
`define SLOT_MEM_QUEUED 5
`define SLOT_CTX_EXHAUST 6
`define SLOT_UNTRANS 7
`define SLOT_MALFORMED 8
`define SLOT_LOGGED_ON 9
`define SLOT_GUEST 10
`define SLOT_MEM_SERVED 11
`define SLOT_OPS_STARTED 12
`define SLOT_IDLE_EXP 13
`define SLOT_BAD_OPCODE 14
`define SLOT_OPS_DONE 15
`define SLOT_CHAN_SERVED 16
`define SLOT_NO_RACK 17
`define SLOT_SCAN_END 18
`define SLOT_LOGIC_HOOK 19
`define SLOT_POWERUP 20
`define SLOT_EXIT_DIM 21

`endif

// file: core/event_counter.v
// Up/down statistics counter, wraps when counting up
`timescale 1ns/1ns
`default_nettype none
module event_counter #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Control
  input wire clear,
  input wire up,
  input wire down,
  // Value
  output reg [WIDTH-1:0] count
);
  reg [WIDTH-1:0] next_count;

  always @* begin
    next_count = count;
    if (up && !down) begin
      next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (down && !up && count != {WIDTH{1'b0}}) begin
      next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
    // An event in the zeroing cycle still counts
    if (clear) begin
      next_count = {{(WIDTH-1){1'b0}}, up && !down};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= {WIDTH{1'b0}};
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// file: core/fault_lamp_timer.v
// Retriggerable hold timer for the fault indicators
`timescale 1ns/1ns
`default_nettype none
module fault_lamp_timer #(
  parameter [31:0] HOLD_CYCLES = 32'd25000000
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Trigger and lamp
  input wire trigger,
  output reg lit
);
  reg [31:0] timer;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer <= 32'h0;
      lit <= 1'b0;
    end else if (trigger) begin
      timer <= HOLD_CYCLES;
      lit <= 1'b1;
    end else begin
      if (timer != 32'h0) begin
        timer <= timer - 32'h1;
      end
      lit <= (timer > 32'h1);
    end
  end
endmodule
`default_nettype wire

// file: core/backplane_port_statistics.v
// Backplane port statistics bank with AHB-Lite register access
//
// Behaviour
// - Any error counter increment lights red and green fault lamps one second.
// - Count each reply arriving from the host controller.
// - Count each error response this device produces toward the backplane.
// - Count ladder block replies dropped for lack of a matching open context.
// - Count each message this device originates onto the backplane.
// - Count each time no free buffer is available for backplane traffic.
// - Count each memory-access request placed in the host service queue.
// - At most four active ladder blocks; fifth counts and waits for release.
// - Live gauge of active ladder blocks, up on activation, down on a release with no block waiting.
// - Count network messages dropped as untranslatable for the host.
// - Count malformed messages, checksum and framing faults included.
// - One master holds logon; count its messages apart from other masters.
// - Count queued memory-access requests serviced by the host.
// - Count ladder block instructions issued by the host.
// - Idle timer on programming channel drops connection and counts on expiry.
// - Count ladder blocks issued with an unsupported operation code.
// - Count completed ladder block operations.
// - Count messages the host services on the backplane channel.
// - Requests before host communication opens get an error and are counted.
// - That error response carries exception code 0x0A, gateway path unavailable.
// - Gauge of buffers the port currently holds.
// - Count scan_end_hooks from the host.
// - Count ladder block scans with enable input energised.
`timescale 1ns/1ns
`default_nettype none
`include "backplane_stats_defs.vh"
module backplane_port_statistics #(
  parameter [31:0] FAULT_HOLD_CYCLES = `FAULT_HOLD_CYCLES,
  parameter [31:0] IDLE_TIMEOUT_CYCLES = `IDLE_TIMEOUT_CYCLES,
  parameter MASTER_ID_WIDTH = 8
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Backplane traffic events, one-cycle pulses
  input wire reply_rx,
  input wire error_resp_made,
  input wire orphan_reply,
  input wire msg_originated,
  input wire buffer_starved,
  input wire mem_req_queued,
  input wire mem_req_served,
  input wire untranslatable,
  input wire malformed_msg,
  input wire channel_msg_served,
  // Ladder message block events, one-cycle pulses
  input wire block_instr,
  input wire block_bad_opcode,
  input wire block_done,
  input wire block_activate,
  input wire block_release,
  // Host hooks, one-cycle pulses
  input wire scan_end_hook,
  input wire logic_hook,
  input wire powerup_hook,
  input wire exit_dim_hook,
  // Buffer and queue occupancy, one-cycle pulses
  input wire buffer_take,
  input wire buffer_give,
  input wire queue_push,
  input wire queue_pop,
  // Channel masters and logon
  input wire channel_msg,
  input wire [MASTER_ID_WIDTH-1:0] channel_master,
  input wire logon_claim,
  input wire logon_drop,
  input wire prog_activity,
  // Host readiness and incoming requests
  input wire host_comm_open,
  input wire master_request,
  // Ladder block context answers
  output reg block_granted,
  output reg block_waiting,
  // Error response toward the master
  output reg gateway_error,
  output reg [7:0] gateway_exc_code,
  // Programming connection
  output reg prog_conn_expired,
  output reg logon_active,
  // Fault indicators
  output wire fault_red,
  output wire fault_green
);
  localparam W = `STAT_WIDTH;
  localparam N = `NUM_COUNTERS;

  // Bus state
  reg wr_pending;
  reg [11:0] wr_index;
  reg lamp_enable;
  reg zero_stats;
  reg [31:0] read_value;
  wire [11:0] addr_index;
  wire addr_in_range;
  wire take_phase;

  // Block state
  reg [2:0] active_blocks;
  reg [3:0] pending_blocks;
  reg [2:0] next_active;
  reg [3:0] next_pending;
  reg next_grant;
  reg context_short;

  // Logon and idle timer
  reg [MASTER_ID_WIDTH-1:0] logon_owner;
  reg [31:0] idle_timer;
  wire owner_msg;
  wire idle_expire;
  wire no_rack;
  wire any_error;
  wire lamp_lit;

  // Counter plumbing
  wire [N-1:0] stat_inc;
  wire [N*W-1:0] stat_val;
  wire [W-1:0] queued_gauge;
  wire [W-1:0] held_gauge;

  // Address phase capture
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take_phase = hsel && htrans[1] && hready;
  assign addr_index = haddr[13:2];
  assign addr_in_range = (haddr[31:14] == 18'h0);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_index <= 12'h0;
    end else if (hready) begin
      wr_pending <= take_phase && hwrite && addr_in_range;
      wr_index <= addr_index;
    end
  end

  // Control register write in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp_enable <= `CTRL_LAMP_EN_RESET;
      zero_stats <= 1'b0;
    end else begin
      zero_stats <= 1'b0;
      if (wr_pending && wr_index == `REG_STATS_CONTROL) begin
        lamp_enable <= hwdata[`CTRL_LAMP_EN_BIT];
        zero_stats <= hwdata[`CTRL_ZERO_BIT];
      end
    end
  end

  // Read data sampled at the address phase
  always @* begin
    read_value = 32'h0;
    case (addr_index)
      `REG_REPLIES_RECEIVED: read_value[W-1:0] = stat_val[`SLOT_REPLIES*W +: W];
      `REG_ERROR_RESPONSES_MADE: read_value[W-1:0] = stat_val[`SLOT_ERR_RESP*W +: W];
      `REG_ORPHAN_REPLIES_DROPPED: read_value[W-1:0] = stat_val[`SLOT_ORPHAN*W +: W];
      `REG_MESSAGES_ORIGINATED: read_value[W-1:0] = stat_val[`SLOT_ORIGINATED*W +: W];
      `REG_BUFFER_STARVATION: read_value[W-1:0] = stat_val[`SLOT_STARVED*W +: W];
      `REG_MEMORY_REQUESTS_QUEUED: read_value[W-1:0] = stat_val[`SLOT_MEM_QUEUED*W +: W];
      `REG_CONTEXT_EXHAUSTED: read_value[W-1:0] = stat_val[`SLOT_CTX_EXHAUST*W +: W];
      `REG_ACTIVE_BLOCK_GAUGE: read_value[2:0] = active_blocks;
      `REG_UNTRANSLATABLE_DROPPED: read_value[W-1:0] = stat_val[`SLOT_UNTRANS*W +: W];
      `REG_MALFORMED_MESSAGES: read_value[W-1:0] = stat_val[`SLOT_MALFORMED*W +: W];
      `REG_LOGGED_ON_CHANNEL_MSGS: read_value[W-1:0] = stat_val[`SLOT_LOGGED_ON*W +: W];
      `REG_GUEST_CHANNEL_MSGS: read_value[W-1:0] = stat_val[`SLOT_GUEST*W +: W];
      `REG_MEMORY_REQUESTS_SERVED: read_value[W-1:0] = stat_val[`SLOT_MEM_SERVED*W +: W];
      `REG_BLOCK_OPS_STARTED: read_value[W-1:0] = stat_val[`SLOT_OPS_STARTED*W +: W];
      `REG_IDLE_EXPIRIES: read_value[W-1:0] = stat_val[`SLOT_IDLE_EXP*W +: W];
      `REG_BAD_OPCODE_COUNT: read_value[W-1:0] = stat_val[`SLOT_BAD_OPCODE*W +: W];
      `REG_BLOCK_OPS_DONE: read_value[W-1:0] = stat_val[`SLOT_OPS_DONE*W +: W];
      `REG_CHANNEL_MSGS_SERVED: read_value[W-1:0] = stat_val[`SLOT_CHAN_SERVED*W +: W];
      `REG_NO_RACK_ERRORS: read_value[W-1:0] = stat_val[`SLOT_NO_RACK*W +: W];
      `REG_SCAN_END_HOOKS: read_value[W-1:0] = stat_val[`SLOT_SCAN_END*W +: W];
      `REG_LOGIC_HOOKS: read_value[W-1:0] = stat_val[`SLOT_LOGIC_HOOK*W +: W];
      `REG_QUEUED_BUFFER_GAUGE: read_value[W-1:0] = queued_gauge;
      `REG_LOGON_CLAIMED: begin
        // Zero while nobody holds the logon
        read_value[MASTER_ID_WIDTH-1:0] = logon_active ? logon_owner : {MASTER_ID_WIDTH{1'b0}};
        read_value[MASTER_ID_WIDTH] = logon_active;
      end
      `REG_POWERUP_HOOKS: read_value[W-1:0] = stat_val[`SLOT_POWERUP*W +: W];
      `REG_EXIT_DIM_HOOKS: read_value[W-1:0] = stat_val[`SLOT_EXIT_DIM*W +: W];
      `REG_BUFFERS_HELD_GAUGE: read_value[W-1:0] = held_gauge;
      `REG_STATS_CONTROL: read_value[`CTRL_LAMP_EN_BIT] = lamp_enable;
      `REG_PORT_STATUS: begin
        read_value[0] = lamp_lit;
        read_value[1] = host_comm_open;
        read_value[2] = logon_active;
        read_value[3] = block_waiting;
        read_value[7:4] = pending_blocks;
      end
      default: read_value = 32'h0;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (take_phase && !hwrite) begin
      hrdata <= addr_in_range ? read_value : 32'h0;
    end
  end

  // Ladder block contexts: a release hands its context to a waiting block
  always @* begin
    next_active = active_blocks;
    next_pending = pending_blocks;
    next_grant = 1'b0;
    context_short = 1'b0;
    if (block_release) begin
      if (pending_blocks != 4'h0) begin
        next_pending = pending_blocks - 4'h1;
        next_grant = 1'b1;
      end else if (active_blocks != 3'h0) begin
        next_active = active_blocks - 3'h1;
      end
    end
    if (block_activate) begin
      if (next_active < `MAX_ACTIVE_BLOCKS && next_pending == 4'h0) begin
        next_active = next_active + 3'h1;
        next_grant = 1'b1;
      end else begin
        context_short = 1'b1;
        if (next_pending != `PENDING_MAX) begin
          next_pending = next_pending + 4'h1;
        end
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_blocks <= 3'h0;
      pending_blocks <= 4'h0;
      block_granted <= 1'b0;
      block_waiting <= 1'b0;
    end else begin
      active_blocks <= next_active;
      pending_blocks <= next_pending;
      block_granted <= next_grant;
      block_waiting <= (next_pending != 4'h0);
    end
  end

  // Logon ownership and programming idle timer
  assign owner_msg = channel_msg && logon_active && channel_master == logon_owner;
  assign idle_expire = logon_active && !prog_activity && !owner_msg &&
                       idle_timer >= IDLE_TIMEOUT_CYCLES - 32'h1;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      logon_active <= 1'b0;
      logon_owner <= {MASTER_ID_WIDTH{1'b0}};
      idle_timer <= 32'h0;
      prog_conn_expired <= 1'b0;
    end else begin
      prog_conn_expired <= idle_expire;
      if (idle_expire || (logon_drop && logon_active && channel_master == logon_owner)) begin
        logon_active <= 1'b0;
      end else if (logon_claim && !logon_active) begin
        logon_active <= 1'b1;
        logon_owner <= channel_master;
      end
      if (!logon_active || prog_activity || owner_msg || idle_expire) begin
        idle_timer <= 32'h0;
      end else begin
        idle_timer <= idle_timer + 32'h1;
      end
    end
  end

  // Requests while the host has not opened communication
  assign no_rack = master_request && !host_comm_open;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gateway_error <= 1'b0;
      gateway_exc_code <= 8'h00;
    end else begin
      gateway_error <= no_rack;
      if (no_rack) begin
        gateway_exc_code <= `EXC_GATEWAY_PATH;
      end
    end
  end

  // Event to counter wiring
  assign stat_inc[`SLOT_REPLIES] = reply_rx;
  assign stat_inc[`SLOT_ERR_RESP] = error_resp_made || no_rack;
  assign stat_inc[`SLOT_ORPHAN] = orphan_reply;
  assign stat_inc[`SLOT_ORIGINATED] = msg_originated;
  assign stat_inc[`SLOT_STARVED] = buffer_starved;
  assign stat_inc[`SLOT_MEM_QUEUED] = mem_req_queued;
  assign stat_inc[`SLOT_CTX_EXHAUST] = context_short;
  assign stat_inc[`SLOT_UNTRANS] = untranslatable;
  assign stat_inc[`SLOT_MALFORMED] = malformed_msg;
  assign stat_inc[`SLOT_LOGGED_ON] = owner_msg;
  assign stat_inc[`SLOT_GUEST] = channel_msg && !owner_msg;
  assign stat_inc[`SLOT_MEM_SERVED] = mem_req_served;
  assign stat_inc[`SLOT_OPS_STARTED] = block_instr;
  assign stat_inc[`SLOT_IDLE_EXP] = idle_expire;
  assign stat_inc[`SLOT_BAD_OPCODE] = block_bad_opcode;
  assign stat_inc[`SLOT_OPS_DONE] = block_done;
  assign stat_inc[`SLOT_CHAN_SERVED] = channel_msg_served;
  assign stat_inc[`SLOT_NO_RACK] = no_rack;
  assign stat_inc[`SLOT_SCAN_END] = scan_end_hook;
  assign stat_inc[`SLOT_LOGIC_HOOK] = logic_hook;
  assign stat_inc[`SLOT_POWERUP] = powerup_hook;
  assign stat_inc[`SLOT_EXIT_DIM] = exit_dim_hook;

  // Sixteen-bit wrapping counters, zeroed at reset or on request
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : stat
      event_counter #(
        .WIDTH(W)
      ) counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(zero_stats),
        .up(stat_inc[g]),
        .down(1'b0),
        .count(stat_val[g*W +: W])
      );
    end
  endgenerate

  // Occupancy gauges follow live state and are zeroed only at reset
  event_counter #(
    .WIDTH(W)
  ) queued_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(1'b0),
    .up(queue_push),
    .down(queue_pop),
    .count(queued_gauge)
  );

  event_counter #(
    .WIDTH(W)
  ) held_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(1'b0),
    .up(buffer_take),
    .down(buffer_give),
    .count(held_gauge)
  );

  // Any error count lights both fault lamps
  assign any_error = stat_inc[`SLOT_ERR_RESP] || orphan_reply || buffer_starved ||
                     context_short || untranslatable || malformed_msg ||
                     idle_expire || block_bad_opcode || no_rack;

  fault_lamp_timer #(
    .HOLD_CYCLES(FAULT_HOLD_CYCLES)
  ) lamp (
    .hclk(hclk),
    .hresetn(hresetn),
    .trigger(any_error && lamp_enable),
    .lit(lamp_lit)
  );

  assign fault_red = lamp_lit;
  assign fault_green = lamp_lit;
endmodule
`default_nettype wire

// file: bench/backplane_port_statistics_checker.sv
// Concurrent checks on the statistics bank ports
`timescale 1ns/1ns
`default_nettype none
module backplane_port_statistics_checker #(
  parameter [31:0] FAULT_HOLD_CYCLES = 32'h14,
  parameter [31:0] IDLE_TIMEOUT_CYCLES = 32'h32
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Watched inputs
  input wire error_resp_made,
  input wire orphan_reply,
  input wire buffer_starved,
  input wire untranslatable,
  input wire malformed_msg,
  input wire block_bad_opcode,
  input wire block_release,
  input wire master_request,
  input wire host_comm_open,
  input wire logon_claim,
  input wire prog_activity,
  input wire channel_msg,
  // Watched outputs
  input wire block_granted,
  input wire block_waiting,
  input wire gateway_error,
  input wire [7:0] gateway_exc_code,
  input wire prog_conn_expired,
  input wire logon_active,
  input wire hreadyout,
  input wire hresp,
  input wire fault_red,
  input wire fault_green
);
  logic [31:0] since;
  logic [31:0] idle_cnt;
  wire err_ext = error_resp_made | orphan_reply | buffer_starved | untranslatable
    | malformed_msg | block_bad_opcode;

  // Cycles since the last error pulse, and since the last logon activity
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since <= FAULT_HOLD_CYCLES;
      idle_cnt <= 32'h0;
    end else begin
      if (err_ext) begin
        since <= 32'h0;
      end else if (since < FAULT_HOLD_CYCLES) begin
        since <= since + 32'h1;
      end
      if (!logon_active || prog_activity || channel_msg) begin
        idle_cnt <= 32'h0;
      end else begin
        idle_cnt <= idle_cnt + 32'h1;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  lamp_pair_a: assert property (fault_red == fault_green)
    else $error("fault lamps disagree");
  lamp_hold_a: assert property (since < FAULT_HOLD_CYCLES |-> fault_red)
    else $error("fault lamp dark within hold time");
  rack_lamp_a: assert property (master_request && !host_comm_open |-> ##[1:2] fault_red)
    else $error("no lamp after refused request");
  ctx_grant_a: assert property (block_release && block_waiting |=> block_granted)
    else $error("waiting block not granted on release");
  no_rack_a: assert property (master_request && !host_comm_open |=> gateway_error)
    else $error("no error answer while host closed");
  gate_cause_a: assert property ($rose(gateway_error) |-> $past(master_request && !host_comm_open))
    else $error("error answer without cause");
  exc_code_a: assert property (gateway_error |-> gateway_exc_code == 8'h0A)
    else $error("wrong exception code");
  idle_bound_a: assert property (logon_active |-> idle_cnt <= IDLE_TIMEOUT_CYCLES + 32'h2)
    else $error("idle logon not expired");
  expire_drop_a: assert property (prog_conn_expired |-> ##[0:1] !logon_active)
    else $error("logon kept after expiry");
  logon_take_a: assert property (logon_claim && !logon_active |=> logon_active)
    else $error("free logon not taken");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
endmodule
`default_nettype wire

// file: bench/host_controller_model.sv
// Behavioural host controller on the backplane side
`timescale 1ns/1ns
`default_nettype none
module host_controller_model #(
  parameter [15:0] BOOT_CYCLES = 16'h0190
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Commands from the bench
  input wire logic go,
  input wire logic [3:0] sel,
  input wire logic [3:0] lag,
  // Backplane side
  output logic [8:0] hev,
  output logic host_comm_open
);
  logic [15:0] boot;
  logic [4:0] cnt;
  logic [3:0] pend;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hev <= 9'h0;
      boot <= 16'h0;
      cnt <= 5'h0;
      pend <= 4'h0;
      host_comm_open <= 1'b0;
    end else begin
      hev <= 9'h0;
      // Opens communication only once booted; answers are not held back by boot
      if (boot == BOOT_CYCLES) begin
        host_comm_open <= 1'b1;
      end else begin
        boot <= boot + 16'h1;
      end
      // Answer promptly or after lag cycles
      if (go) begin
        cnt <= {1'b0, lag} + 5'h1;
        pend <= sel;
      end else if (cnt == 5'h1) begin
        hev[pend] <= 1'b1;
        cnt <= 5'h0;
      end else if (cnt != 5'h0) begin
        cnt <= cnt - 5'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/backplane_port_statistics_tb_top.sv
// Self-checking bench for the backplane port statistics bank
`timescale 1ns/1ns
`default_nettype none
module backplane_port_statistics_tb_top;
  logic hclk, hresetn, hsel, hwrite, go, dphase;
  logic [31:0] haddr, hwdata, e;
  logic [1:0] htrans;
  logic [18:0] dv;
  logic [7:0] chm, a;
  logic [3:0] sel, lagv;
  wire [8:0] hev;
  wire hco, hreadyout, hresp, bgr, bwait, gerr, pexp, lact, fred, fgrn;
  wire [31:0] hrdata;
  wire [7:0] gcode;
  int fails, cmp_count, cyc, i, n;
  logic [31:0] expq[$];
  logic [11:0] hidx [9] = '{12'h861, 12'h86D, 12'h872, 12'h86E, 12'h871, 12'h875, 12'h876,
    12'h879, 12'h87A};
  logic [11:0] didx [8] = '{12'h862, 12'h863, 12'h864, 12'h865, 12'h866, 12'h869, 12'h86A,
    12'h870};

  backplane_port_statistics #(.FAULT_HOLD_CYCLES(32'h14), .IDLE_TIMEOUT_CYCLES(32'h32)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .reply_rx(hev[0]), .error_resp_made(dv[0]), .orphan_reply(dv[1]), .msg_originated(dv[2]),
    .buffer_starved(dv[3]), .mem_req_queued(dv[4]), .mem_req_served(hev[1]),
    .untranslatable(dv[5]), .malformed_msg(dv[6]), .channel_msg_served(hev[2]),
    .block_instr(hev[3]), .block_bad_opcode(dv[7]), .block_done(hev[4]),
    .block_activate(dv[8]), .block_release(dv[9]), .scan_end_hook(hev[5]),
    .logic_hook(hev[6]), .powerup_hook(hev[7]), .exit_dim_hook(hev[8]),
    .buffer_take(dv[10]), .buffer_give(dv[11]), .queue_push(dv[12]), .queue_pop(dv[13]),
    .channel_msg(dv[14]), .channel_master(chm), .logon_claim(dv[15]), .logon_drop(dv[16]),
    .prog_activity(dv[17]), .host_comm_open(hco), .master_request(dv[18]),
    .block_granted(bgr), .block_waiting(bwait), .gateway_error(gerr), .gateway_exc_code(gcode),
    .prog_conn_expired(pexp), .logon_active(lact), .fault_red(fred), .fault_green(fgrn));

  host_controller_model host (.hclk(hclk), .hresetn(hresetn), .go(go), .sel(sel),
    .lag(lagv), .hev(hev), .host_comm_open(hco));

  always #20 hclk = ~hclk;

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One single AHB transfer; a read notes its expected word
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    dphase <= !w;
    if (!w) expq.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    dphase <= 1'b0;
  endtask

  task automatic pulse(input int b, input int k);
    @(posedge hclk);
    dv[b] <= 1'b1;
    repeat (k) @(posedge hclk);
    dv[b] <= 1'b0;
  endtask

  task automatic hst(input logic [3:0] b, input logic [3:0] lg);
    @(posedge hclk);
    go <= 1'b1;
    sel <= b;
    lagv <= lg;
    @(posedge hclk);
    go <= 1'b0;
    repeat (lg + 4) @(posedge hclk);
  endtask

  // Read data checked at the data-phase edge
  always @(posedge hclk) begin
    if (dphase) begin
      cmp_count++;
      e = expq.pop_front();
      if (hrdata !== e) begin
        fails++;
        $display("mismatch at %0t: got %h expected %h", $time, hrdata, e);
      end
    end
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hwdata = 32'h0;
    dphase = 1'b0;
    dv = 19'h0;
    chm = 8'h0;
    go = 1'b0;
    sel = 4'h0;
    lagv = 4'h0;
    n = $urandom(32'h0E875897);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 32'h861; i <= 32'h880; i++) xfer(1'b0, 12'(i), 32'h0);
    xfer(1'b0, 12'h881, 32'h2);
    pulse(18, 1);
    xfer(1'b0, 12'h873, 32'h1);
    xfer(1'b0, 12'h862, 32'h1);
    while (hco !== 1'b1) @(posedge hclk);
    xfer(1'b1, 12'h881, 32'h3);
    xfer(1'b1, 12'h873, 32'hFFFF);
    xfer(1'b0, 12'h873, 32'h0);
    for (i = 0; i < 9; i++) begin
      n = 1 + int'($urandom % 3);
      repeat (n) hst(4'(i), (i % 2) ? 4'h5 : 4'h0);
      xfer(1'b0, hidx[i], 32'(n));
    end
    for (i = 0; i < 8; i++) begin
      n = 1 + int'($urandom % 4);
      pulse(i, n);
      xfer(1'b0, didx[i], 32'(n));
    end
    pulse(8, 5);
    xfer(1'b0, 12'h868, 32'h4);
    xfer(1'b0, 12'h867, 32'h1);
    pulse(9, 1);
    xfer(1'b0, 12'h868, 32'h4);
    pulse(9, 1);
    xfer(1'b0, 12'h868, 32'h3);
    pulse(10, 3);
    pulse(11, 1);
    xfer(1'b0, 12'h880, 32'h2);
    pulse(12, 2);
    pulse(13, 3);
    xfer(1'b0, 12'h877, 32'h0);
    a = 8'($urandom);
    @(posedge hclk);
    chm <= a;
    pulse(15, 1);
    xfer(1'b0, 12'h878, {23'h0, 1'b1, a});
    pulse(14, 2);
    @(posedge hclk);
    chm <= a ^ 8'h1;
    pulse(14, 1);
    xfer(1'b0, 12'h86B, 32'h2);
    xfer(1'b0, 12'h86C, 32'h1);
    repeat (60) @(posedge hclk);
    xfer(1'b0, 12'h86F, 32'h1);
    xfer(1'b0, 12'h878, 32'h0);
    pulse(15, 1);
    pulse(17, 1);
    xfer(1'b0, 12'h878, {23'h0, 1'b1, a ^ 8'h1});
    pulse(16, 1);
    xfer(1'b0, 12'h878, 32'h0);
    repeat (30) @(posedge hclk);
    xfer(1'b0, 12'h882, 32'h2);
    xfer(1'b1, 12'h881, 32'h3);
    pulse(1, 65537);
    xfer(1'b0, 12'h863, 32'h1);
    report_and_stop();
  end
endmodule

bind backplane_port_statistics backplane_port_statistics_checker #(
  .FAULT_HOLD_CYCLES(FAULT_HOLD_CYCLES), .IDLE_TIMEOUT_CYCLES(IDLE_TIMEOUT_CYCLES)) chk (
  .hclk(hclk), .hresetn(hresetn), .error_resp_made(error_resp_made),
  .orphan_reply(orphan_reply), .buffer_starved(buffer_starved),
  .untranslatable(untranslatable), .malformed_msg(malformed_msg),
  .block_bad_opcode(block_bad_opcode), .block_release(block_release),
  .master_request(master_request), .host_comm_open(host_comm_open),
  .logon_claim(logon_claim), .prog_activity(prog_activity), .channel_msg(channel_msg),
  .block_granted(block_granted), .block_waiting(block_waiting),
  .gateway_error(gateway_error), .gateway_exc_code(gateway_exc_code),
  .prog_conn_expired(prog_conn_expired), .logon_active(logon_active),
  .hreadyout(hreadyout), .hresp(hresp), .fault_red(fault_red), .fault_green(fault_green));
`default_nettype wire
